// *** design/dmsdc_top.v ***
/*
 Converter mode selection, sequencer fetch engine, sequencer queue and
 conversion timing, reached by software over AXI4-Lite.
 Assumes memory answers each request with one ack or err pulse, and that
 all inputs but the conversion clock pin share clock.
*/
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dmsdc_defs.vh"

// How it works
// RULE_01 - Immediate style: update after channel data transfer
// RULE_02 - Controlled style: update all on global write
// RULE_03 - Manual mode: software-commanded updates, no periodic timing
// RULE_04 - Sequencer mode: periodic update at conversion rate
// RULE_05 - Mode selects whole converter, all four channels
// RULE_06 - Sequencer converters all convert at once
// RULE_07 - Each conversion refreshes all four channels
// RULE_08 - Normal mode: one block or continuous, software started
// RULE_09 - Frame mode: blocks started by recurring frame trigger
// RULE_10 - Values fetched by DMA into internal queue
// RULE_11 - Fetch reset bit resets engine, self-clears
// RULE_12 - Length write starts fetch only when enabled
// RULE_13 - Disable finishes current transfer before idle
// RULE_14 - Fetch error halts engine until disabled
// RULE_15 - Disabled fetch engine held in reset
// RULE_16 - Queue clear bit empties queue, self-clears
// RULE_17 - Normal block starts at next conversion clock
// RULE_18 - Frame block starts at next conversion clock
// RULE_19 - Early or unloaded trigger stops, flags error
// RULE_20 - Command bits and reserved bits read zero
module dmsdc_top (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // AXI4-Lite slave
    input wire [11:0] s_awaddr,
    input wire s_awvalid,
    output wire s_awready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output wire s_wready,
    output reg [1:0] s_bresp,
    output reg s_bvalid,
    input wire s_bready,
    input wire [11:0] s_araddr,
    input wire s_arvalid,
    output wire s_arready,
    output reg [31:0] s_rdata,
    output reg [1:0] s_rresp,
    output reg s_rvalid,
    input wire s_rready,
    // Host memory read port
    output reg mem_req,
    output reg [31:0] mem_addr,
    input wire mem_ack,
    input wire mem_err,
    input wire [31:0] mem_rdata,
    // Conversion clock two pin
    input wire conv_clk2_pin,
    // Manual path events
    input wire [1:0] man_xfer_done,
    input wire glob_update,
    // Converter outputs
    output reg [1:0] dac_update,
    output reg [127:0] seq_data
);

    localparam [1:0] DMA_IDLE = 2'b00;
    localparam [1:0] DMA_RUN = 2'b01;
    localparam [1:0] DMA_ERR = 2'b10;
    localparam [10:0] SETTLE_CYC = `DMSDC_SETTLE_CYC;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [1:0] mode0_r, mode1_r;
    reg dma_en_r, ou_en_r, ou_frame_r, clk_src_r;
    reg dma_rst_p, q_clr_p, ou_rst_p, pre_clr_p, start_p, len_wr_p;
    reg [31:0] dma_adr_r;
    reg [15:0] dma_len_r, cnv_cnt_r, dma_left_r, cnv_left_r;
    reg [23:0] cnv_per_r, frm_per_r;
    reg [1:0] dma_st_r;
    reg [4:0] q_wp_r, q_rp_r;
    reg [31:0] q_mem [0:15];
    reg [2:0] load_r;
    reg [127:0] hold_r;
    reg [10:0] settle_r;
    reg arm_r, run_r, ou_err_r;
    reg c2_s1_r, c2_s2_r, c2_s3_r;
    reg aw_full_r, w_full_r;
    reg [11:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    integer i, j;

    wire [4:0] q_cnt = q_wp_r - q_rp_r;
    wire q_in_rdy = (q_cnt != `DMSDC_QDEPTH);
    wire q_out_val = (q_cnt != 5'h00);
    wire [1:0] seq_mask = {mode1_r[`DMSDC_B_MODE], mode0_r[`DMSDC_B_MODE]}; // RULE_05
    wire loaded = load_r[2];
    wire ou_clr = ou_rst_p | ~ou_en_r;
    wire int_tick, frm_tick;
    wire c2_tick = c2_s2_r & ~c2_s3_r;
    wire cnv_tick = ou_en_r & (clk_src_r ? c2_tick : int_tick);
    wire want_load = ou_en_r & ~ou_err_r & ~loaded;
    wire skip_word = ~seq_mask[load_r[1]];
    wire q_pop = want_load & ~skip_word & q_out_val;
    wire q_push = (dma_st_r == DMA_RUN) & mem_req & mem_ack & ~mem_err;
    wire conv_go = cnv_tick & (arm_r | run_r) & ~ou_err_r;
    wire conv_bad = ~loaded | (settle_r != 11'h000);
    wire [15:0] cur_left = arm_r ? cnv_cnt_r : cnv_left_r;

    // ----------------------------------------------------------------
    // Register access helpers
    // ----------------------------------------------------------------
    function [31:0] rmux;
        input [11:0] a;
        begin
            rmux = `DMSDC_RST32;
            if (a == `DMSDC_A_MODE0) begin
                rmux = {30'h0, mode0_r};
            end else if (a == `DMSDC_A_MODE1) begin
                rmux = {30'h0, mode1_r};
            end else if (a == `DMSDC_A_SEQCTL) begin
                rmux = {15'h0, dma_en_r, 10'h0, clk_src_r, 2'h0, ou_frame_r, 1'b0, ou_en_r}; // RULE_20
            end else if (a == `DMSDC_A_DMAADR) begin
                rmux = dma_adr_r;
            end else if (a == `DMSDC_A_DMALEN) begin
                rmux = {16'h0, dma_len_r};
            end else if (a == `DMSDC_A_CNVCNT) begin
                rmux = {16'h0, cnv_cnt_r};
            end else if (a == `DMSDC_A_CNVPER) begin
                rmux = {8'h0, cnv_per_r};
            end else if (a == `DMSDC_A_FRMPER) begin
                rmux = {8'h0, frm_per_r};
            end else if (a == `DMSDC_A_STATE) begin
                rmux = {19'h0, q_cnt, 3'h0, arm_r | run_r, ou_err_r, loaded,
                        dma_st_r == DMA_ERR, dma_st_r == DMA_RUN};
            end
        end
    endfunction

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `DMSDC_A_MODE0) || (a == `DMSDC_A_MODE1) ||
                     (a == `DMSDC_A_SEQCTL) || (a == `DMSDC_A_DMAADR) ||
                     (a == `DMSDC_A_DMALEN) || (a == `DMSDC_A_CNVCNT) ||
                     (a == `DMSDC_A_CNVPER) || (a == `DMSDC_A_FRMPER) ||
                     (a == `DMSDC_A_STATE);
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    // Address and data arrive in either order; the answer waits for both.
    assign s_awready = ~aw_full_r;
    assign s_wready = ~w_full_r;
    assign s_arready = ~s_rvalid;
    wire wr_fire = aw_full_r & w_full_r & ~s_bvalid;
    wire [31:0] wv = merge(rmux(aw_addr_r), w_data_r, w_strb_r);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= `DMSDC_RST32;
            w_strb_r <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= `DMSDC_OKAY;
            s_rvalid <= 1'b0;
            s_rresp <= `DMSDC_OKAY;
            s_rdata <= `DMSDC_RST32;
        end else begin
            if (s_awvalid && !aw_full_r) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_awaddr;
            end
            if (s_wvalid && !w_full_r) begin
                w_full_r <= 1'b1;
                w_data_r <= s_wdata;
                w_strb_r <= s_wstrb;
            end
            if (wr_fire) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= mapped(aw_addr_r) ? `DMSDC_OKAY : `DMSDC_SLVERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
            if (s_arvalid && !s_rvalid) begin
                s_rvalid <= 1'b1;
                s_rdata <= rmux(s_araddr);
                s_rresp <= mapped(s_araddr) ? `DMSDC_OKAY : `DMSDC_SLVERR;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // Control register writes; command bits live one cycle only.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode0_r <= 2'b00;
            mode1_r <= 2'b00;
            dma_en_r <= 1'b0;
            ou_en_r <= 1'b0;
            ou_frame_r <= 1'b0;
            clk_src_r <= 1'b0;
            dma_rst_p <= 1'b0;
            q_clr_p <= 1'b0;
            ou_rst_p <= 1'b0;
            pre_clr_p <= 1'b0;
            start_p <= 1'b0;
            len_wr_p <= 1'b0;
            dma_adr_r <= `DMSDC_RST32;
            dma_len_r <= `DMSDC_RST16;
            cnv_cnt_r <= `DMSDC_RST16;
            cnv_per_r <= `DMSDC_PER_RST;
            frm_per_r <= `DMSDC_PER_RST;
        end else begin
            dma_rst_p <= 1'b0; // RULE_11
            q_clr_p <= 1'b0; // RULE_16
            ou_rst_p <= 1'b0;
            pre_clr_p <= 1'b0;
            start_p <= 1'b0;
            len_wr_p <= 1'b0;
            if (wr_fire) begin
                if (aw_addr_r == `DMSDC_A_MODE0) begin
                    mode0_r <= wv[1:0];
                end else if (aw_addr_r == `DMSDC_A_MODE1) begin
                    mode1_r <= wv[1:0];
                end else if (aw_addr_r == `DMSDC_A_SEQCTL) begin
                    dma_en_r <= wv[`DMSDC_B_DMAEN];
                    dma_rst_p <= wv[`DMSDC_B_DMARST]; // RULE_11
                    q_clr_p <= wv[`DMSDC_B_QCLR]; // RULE_16
                    clk_src_r <= wv[`DMSDC_B_CLKSRC];
                    pre_clr_p <= wv[`DMSDC_B_PRECLR];
                    start_p <= wv[`DMSDC_B_START];
                    ou_frame_r <= wv[`DMSDC_B_FRAME];
                    ou_rst_p <= wv[`DMSDC_B_OURST];
                    ou_en_r <= wv[`DMSDC_B_OUEN];
                end else if (aw_addr_r == `DMSDC_A_DMAADR) begin
                    dma_adr_r <= wv;
                end else if (aw_addr_r == `DMSDC_A_DMALEN) begin
                    dma_len_r <= wv[15:0];
                    len_wr_p <= 1'b1;
                end else if (aw_addr_r == `DMSDC_A_CNVCNT) begin
                    cnv_cnt_r <= wv[15:0];
                end else if (aw_addr_r == `DMSDC_A_CNVPER) begin
                    cnv_per_r <= wv[23:0];
                end else if (aw_addr_r == `DMSDC_A_FRMPER) begin
                    frm_per_r <= wv[23:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Fetch engine
    // ----------------------------------------------------------------
    // A request is raised only while the queue has room, so a returned
    // word is never dropped.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dma_st_r <= DMA_IDLE;
            mem_req <= 1'b0;
            mem_addr <= `DMSDC_RST32;
            dma_left_r <= `DMSDC_RST16;
        end else if (dma_rst_p) begin
            dma_st_r <= DMA_IDLE; // RULE_11
            mem_req <= 1'b0;
        end else begin
            case (dma_st_r)
                DMA_IDLE: begin
                    if (len_wr_p && dma_en_r && dma_len_r != `DMSDC_RST16) begin
                        dma_st_r <= DMA_RUN; // RULE_12
                        mem_addr <= dma_adr_r;
                        dma_left_r <= dma_len_r;
                    end
                end
                DMA_RUN: begin
                    if (mem_req) begin
                        if (mem_err) begin
                            mem_req <= 1'b0;
                            dma_st_r <= DMA_ERR; // RULE_14
                        end else if (mem_ack) begin
                            mem_req <= 1'b0;
                            mem_addr <= mem_addr + `DMSDC_ADDR_STEP; // RULE_10
                            dma_left_r <= dma_left_r - 16'h0001;
                            if (dma_left_r == 16'h0001 || !dma_en_r) begin
                                dma_st_r <= DMA_IDLE; // RULE_13
                            end
                        end
                    end else if (!dma_en_r) begin
                        dma_st_r <= DMA_IDLE; // RULE_15
                    end else if (q_in_rdy) begin
                        mem_req <= 1'b1;
                    end
                end
                DMA_ERR: begin
                    if (!dma_en_r) begin
                        dma_st_r <= DMA_IDLE; // RULE_15
                    end
                end
                default: begin
                    dma_st_r <= DMA_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Sequencer queue
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q_wp_r <= 5'h00;
            q_rp_r <= 5'h00;
            for (i = 0; i < 16; i = i + 1) begin
                q_mem[i] <= `DMSDC_RST32;
            end
        end else if (q_clr_p) begin
            q_wp_r <= 5'h00; // RULE_16
            q_rp_r <= 5'h00;
        end else begin
            if (q_push) begin
                q_mem[q_wp_r[3:0]] <= mem_rdata; // RULE_10
                q_wp_r <= q_wp_r + 5'h01;
            end
            if (q_pop) begin
                q_rp_r <= q_rp_r + 5'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Conversion timing
    // ----------------------------------------------------------------
    dmsdc_tick u_cnv_tick (
        .clock(clock),
        .rst_n(rst_n),
        .clr(ou_clr),
        .period(cnv_per_r),
        .tick(int_tick)
    );

    dmsdc_tick u_frm_tick (
        .clock(clock),
        .rst_n(rst_n),
        .clr(ou_clr | ~ou_frame_r),
        .period(frm_per_r),
        .tick(frm_tick)
    );

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            c2_s1_r <= 1'b0;
            c2_s2_r <= 1'b0;
            c2_s3_r <= 1'b0;
        end else begin
            c2_s1_r <= conv_clk2_pin;
            c2_s2_r <= c2_s1_r;
            c2_s3_r <= c2_s2_r;
        end
    end

    // Pre-load walks four words: converter in bit 1, channel pair in bit 0.
    // Words of a converter left in manual mode are skipped.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            load_r <= 3'b000;
            hold_r <= {4{`DMSDC_RST32}};
            settle_r <= 11'h000;
            arm_r <= 1'b0;
            run_r <= 1'b0;
            ou_err_r <= 1'b0;
            cnv_left_r <= `DMSDC_RST16;
            seq_data <= {4{`DMSDC_RST32}};
        end else if (ou_clr) begin
            load_r <= 3'b000;
            settle_r <= 11'h000;
            arm_r <= 1'b0;
            run_r <= 1'b0;
            ou_err_r <= 1'b0;
        end else begin
            if (settle_r != 11'h000) begin
                settle_r <= settle_r - 11'h001;
            end
            if (pre_clr_p) begin
                load_r <= 3'b000;
            end else if (want_load && (skip_word || q_out_val)) begin
                load_r <= load_r + 3'b001;
                if (!skip_word) begin
                    hold_r[load_r[1:0]*32 +: 32] <= q_mem[q_rp_r[3:0]];
                end
            end
            if (conv_go) begin
                arm_r <= 1'b0;
                if (conv_bad) begin
                    ou_err_r <= 1'b1; // RULE_19
                    run_r <= 1'b0;
                end else begin
                    seq_data <= hold_r; // RULE_07
                    load_r <= 3'b000;
                    settle_r <= SETTLE_CYC - 11'h001;
                    run_r <= (cur_left != 16'h0001); // RULE_08
                    if (cur_left != `DMSDC_RST16) begin
                        cnv_left_r <= cur_left - 16'h0001;
                    end else begin
                        cnv_left_r <= `DMSDC_RST16;
                    end
                end
            end
            if (start_p && !ou_frame_r) begin
                arm_r <= 1'b1; // RULE_08 RULE_17
            end
            if (frm_tick && ou_frame_r) begin
                arm_r <= 1'b1; // RULE_09 RULE_18
            end
        end
    end

    // ----------------------------------------------------------------
    // Converter update strobes
    // ----------------------------------------------------------------
    // One shared strobe keeps sequencer converters from drifting apart.
    wire seq_fire = conv_go & ~conv_bad & ~ou_clr;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dac_update <= 2'b00;
        end else begin
            for (j = 0; j < 2; j = j + 1) begin
                if (seq_mask[j]) begin
                    dac_update[j] <= seq_fire; // RULE_04 RULE_06
                end else if (j == 0 ? mode0_r[`DMSDC_B_MAN] : mode1_r[`DMSDC_B_MAN]) begin
                    dac_update[j] <= glob_update; // RULE_02 RULE_03
                end else begin
                    dac_update[j] <= man_xfer_done[j]; // RULE_01 RULE_03
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** design/dmsdc_defs.vh ***
/*
 Offsets, field positions, reset values and counts of the converter
 mode and sequencer fetch block.
 Assumes inclusion by bare name.
*/
`ifndef DMSDC_DEFS_VH
`define DMSDC_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define DMSDC_A_MODE0 12'h18c
`define DMSDC_A_MODE1 12'h1bc
`define DMSDC_A_SEQCTL 12'h2e8
`define DMSDC_A_DMAADR 12'h2f0
`define DMSDC_A_DMALEN 12'h2f4
`define DMSDC_A_CNVCNT 12'h2f8
`define DMSDC_A_CNVPER 12'h2fc
`define DMSDC_A_FRMPER 12'h300
`define DMSDC_A_STATE 12'h304

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DMSDC_B_MODE 0
`define DMSDC_B_MAN 1
`define DMSDC_B_DMARST 17
`define DMSDC_B_DMAEN 16
`define DMSDC_B_QCLR 8
`define DMSDC_B_CLKSRC 5
`define DMSDC_B_PRECLR 4
`define DMSDC_B_START 3
`define DMSDC_B_FRAME 2
`define DMSDC_B_OURST 1
`define DMSDC_B_OUEN 0

// ----------------------------------------------------------------
// Reset values and answers
// ----------------------------------------------------------------
`define DMSDC_RST32 32'h0000_0000
`define DMSDC_RST16 16'h0000
`define DMSDC_PER_RST 24'h0007d0
`define DMSDC_OKAY 2'b00
`define DMSDC_SLVERR 2'b10

// ----------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------
`define DMSDC_SETTLE_CYC 11'h7d0
`define DMSDC_QDEPTH 5'h10
`define DMSDC_ADDR_STEP 32'h0000_0004

`endif

// *** design/dmsdc_tick.v ***
/*
 Periodic one-cycle enable pulse from a programmable cycle count.
 Assumes the period input is steady while the divider runs.
*/
`timescale 1ns/1ps
`default_nettype none

module dmsdc_tick (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Control
    input wire clr,
    input wire [23:0] period,
    // Pulse
    output reg tick
);

    reg [23:0] cnt_r;
    wire last = ((cnt_r + 24'h000001) >= period);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 24'h000000;
            tick <= 1'b0;
        end else if (clr) begin
            cnt_r <= 24'h000000;
            tick <= 1'b0;
        end else begin
            tick <= last;
            cnt_r <= last ? 24'h000000 : cnt_r + 24'h000001;
        end
    end

endmodule
`default_nettype wire

// *** tb/dmsdc_monitor.sv ***
/* Port checker for dmsdc_top: register bus handshakes and fetch port.
   Assumes binding into dmsdc_top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module dmsdc_monitor (
    // Clock, reset and register bus
    input wire clock,
    input wire rst_n,
    input wire s_awready,
    input wire s_wready,
    input wire s_bvalid,
    input wire s_bready,
    input wire s_arready,
    input wire s_rvalid,
    input wire s_rready,
    // Fetch port
    input wire mem_req,
    input wire [31:0] mem_addr,
    input wire mem_ack,
    input wire mem_err
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_waiting; mem_req && !mem_ack && !mem_err; endsequence
    sequence s_acked; mem_req && mem_ack; endsequence
    sequence s_failed; mem_req && mem_err; endsequence
    sequence s_rearm; !mem_req ##1 mem_req; endsequence
    chk_bresp_stands: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("write response dropped");
    chk_rdata_stands: assert property (s_rvalid && !s_rready |=> s_rvalid)
        else $error("read response dropped");
    chk_read_refused: assert property (s_rvalid |-> !s_arready)
        else $error("read taken while busy");
    chk_write_done: assert property (!s_awready && !s_wready && !s_bvalid |=> s_bvalid)
        else $error("write not answered");
    chk_fetch_holds: assert property (s_waiting |=> mem_req && $stable(mem_addr))
        else $error("fetch request not held");
    chk_fetch_drops: assert property (mem_req && (mem_ack || mem_err) |=> !mem_req)
        else $error("fetch request not released");
    chk_fetch_step: assert property (s_acked ##1 s_rearm
        |-> mem_addr == $past(mem_addr, 2) + 32'h4) else $error("fetch address step");
    chk_error_halts: assert property (s_failed |=> !mem_req [*8])
        else $error("fetch continued after error");
endmodule
bind dmsdc_top dmsdc_monitor u_mon (.clock, .rst_n, .s_awready, .s_wready, .s_bvalid,
    .s_bready, .s_arready, .s_rvalid, .s_rready, .mem_req, .mem_addr, .mem_ack, .mem_err);
`default_nettype wire

// *** tb/dmsdc_mem.sv ***
/* Host memory model for the fetch port, answering lag plus one cycles after a request is raised.
   Assumes one request held on mem_req until answered. */
`timescale 1ns/1ps
`default_nettype none
module dmsdc_mem (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Fetch port
    input wire mem_req,
    input wire [31:0] mem_addr,
    output logic mem_ack,
    output logic mem_err,
    output logic [31:0] mem_rdata,
    // Test control
    input wire [7:0] lag,
    input wire [31:0] bad_addr
);
    logic [7:0] cnt_r;
    wire go = mem_req && !mem_ack && !mem_err && cnt_r == lag;
    // Data toggles between answers so a stale word never passes as fresh.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
            {mem_ack, mem_err, mem_rdata} <= 34'h0;
        end else begin
            cnt_r <= (mem_req && !mem_ack && !mem_err) ? cnt_r + 8'h01 : 8'h00;
            mem_ack <= go && mem_addr != bad_addr;
            mem_err <= go && mem_addr == bad_addr;
            mem_rdata <= go ? mem_addr ^ 32'ha5a5_0000 : ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/* Self-checking bench for dmsdc_top with a host memory model.
   Assumes the register map of dmsdc_defs.vh. */
`timescale 1ns/1ps
`default_nettype none
`include "dmsdc_defs.vh"
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0, glob_update = 1'b0;
    logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
    logic [31:0] s_wdata = 32'h0, bad = 32'hffff_ffff, rdat;
    logic [1:0] man_xfer_done = 2'h0, rsp, seen;
    logic [7:0] lag = 8'h0;
    int err_count = 0, total_checks = 0, acks = 0;
    wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_req, mem_ack, mem_err;
    wire [1:0] s_bresp, s_rresp, dac_update;
    wire [31:0] s_rdata, mem_addr, mem_rdata;
    wire [127:0] seq_data;
    logic [7:0] tm = 8'h68, te = 8'hb1;
    logic [3:0] tx = 4'hb, tg = 4'hc;
    dmsdc_top dut (.clock, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready(1'b1),
        .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready(1'b1),
        .mem_req, .mem_addr, .mem_ack, .mem_err, .mem_rdata, .conv_clk2_pin(1'b0),
        .man_xfer_done, .glob_update, .dac_update, .seq_data);
    dmsdc_mem u_mem (.clock, .rst_n, .mem_req, .mem_addr, .mem_ack, .mem_err, .mem_rdata,
        .lag, .bad_addr(bad));
    always #2.5 clock = ~clock;
    always @(posedge clock) acks += mem_ack;
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        rsp = s_bresp;
    endtask
    task automatic rd(input logic [11:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rdat = s_rdata;
        rsp = s_rresp;
    endtask
    task automatic chk(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] m, e);
        rd(a);
        chk(rdat & m, e);
    endtask
    task automatic wt(input int k);
        for (int n = 0; n < 900 && acks < k; n++) @(posedge clock);
        repeat (4) @(posedge clock);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rc(`DMSDC_A_SEQCTL, 32'hffff_ffff, 32'h0);
        wr(`DMSDC_A_MODE1, 32'hffff_ffff);
        rc(`DMSDC_A_MODE1, 32'hffff_ffff, 32'h3);
        wr(`DMSDC_A_MODE1, 32'h2);
        wr(`DMSDC_A_SEQCTL, 32'h0002_0118);
        rc(`DMSDC_A_SEQCTL, 32'hffff_ffff, 32'h0);
        wr(12'h004, 32'h1);
        chk({30'h0, rsp}, 32'h2);
        rc(12'h004, 32'hffff_ffff, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            wr(`DMSDC_A_MODE0, {30'h0, tm[2*i +: 2]});
            man_xfer_done <= {1'b0, tx[i]};
            glob_update <= tg[i];
            @(posedge clock);
            man_xfer_done <= 2'h0;
            glob_update <= 1'b0;
            seen = 2'h0;
            repeat (8) @(posedge clock) seen |= dac_update;
            chk({30'h0, seen}, {30'h0, te[2*i +: 2]});
        end
        $display("test manual done");
        wr(`DMSDC_A_DMAADR, 32'h1000);
        wr(`DMSDC_A_DMALEN, 32'h4);
        rc(`DMSDC_A_STATE, 32'h1f01, 32'h0);
        wr(`DMSDC_A_SEQCTL, 32'h0001_0000);
        acks = 0;
        wr(`DMSDC_A_DMALEN, 32'h4);
        wt(4);
        rc(`DMSDC_A_STATE, 32'h1f01, 32'h0400);
        wr(`DMSDC_A_SEQCTL, 32'h0001_0100);
        rc(`DMSDC_A_STATE, 32'h1f00, 32'h0);
        lag <= 8'd20;
        acks = 0;
        wr(`DMSDC_A_DMALEN, 32'h8);
        wr(`DMSDC_A_SEQCTL, 32'h0);
        wt(1);
        rc(`DMSDC_A_STATE, 32'h1f01, 32'h0100);
        wr(`DMSDC_A_SEQCTL, 32'h0001_0100);
        lag <= 8'd0;
        bad <= 32'h1008;
        acks = 0;
        wr(`DMSDC_A_DMALEN, 32'h4);
        wt(2);
        rc(`DMSDC_A_STATE, 32'h1f03, 32'h0202);
        wr(`DMSDC_A_SEQCTL, 32'h0);
        rc(`DMSDC_A_STATE, 32'h2, 32'h0);
        $display("test fetch done");
        bad <= 32'hffff_ffff;
        wr(`DMSDC_A_SEQCTL, 32'h0001_0100);
        wr(`DMSDC_A_MODE0, 32'h1);
        wr(`DMSDC_A_MODE1, 32'h1);
        wr(`DMSDC_A_CNVCNT, 32'h1);
        wr(`DMSDC_A_DMAADR, 32'h1000);
        wr(`DMSDC_A_DMALEN, 32'h8);
        wr(`DMSDC_A_SEQCTL, 32'h0001_0009);
        seen = 2'h0;
        for (int n = 0; n < 5000 && seen == 2'h0; n++) @(posedge clock) seen = dac_update;
        chk({30'h0, seen}, 32'h3);
        chk(seq_data[31:0], 32'ha5a5_1000);
        $display("test sequencer done");
        complete_run();
    end
    initial begin
        #150us;
        err_count++;
        $display("ERROR %0t timeout", $time);
        complete_run();
    end
endmodule
`default_nettype wire
